/* File: pbc_pkg.sv */
// Purpose: Shared constants and types for the loop bandwidth and programming control
// Assumes: One bus clock, byte-wide register port
// Notes: Register offsets are indexes into the three-register block
package pbc_pkg;
   localparam logic [1:0] pbc_off_ctrl = 2'h0;
   localparam logic [1:0] pbc_off_bw = 2'h1;
   localparam logic [1:0] pbc_off_prog = 2'h2;
   // Control register fields
   localparam int pbc_bit_irq_en = 7;
   localparam int pbc_bit_flag = 6;
   localparam int pbc_bit_enable = 5;
   localparam int pbc_bit_select = 4;
   localparam logic [3:0] pbc_ctrl_low_ones = 4'hF;
   // Bandwidth register fields
   localparam int pbc_bit_auto = 7;
   localparam int pbc_bit_lock = 6;
   localparam int pbc_bit_acq = 5;
   localparam int pbc_bit_xloss = 4;
   // Programming register fields
   localparam int pbc_mul_lsb = 4;
   localparam int pbc_vrs_lsb = 0;
   localparam logic [3:0] pbc_mul_reset = 4'h6;
   localparam logic [3:0] pbc_vrs_reset = 4'h6;
   localparam logic [3:0] pbc_mul_min = 4'h1;
   localparam logic pbc_enable_reset = 1'b1;
   // Crystal loss wait is N times this
   localparam int pbc_xloss_factor = 4;
   localparam logic [5:0] pbc_xloss_factor_w = 6'h04;
   typedef enum logic [1:0] {pbc_h_idle, pbc_h_wait, pbc_h_take, pbc_h_done} pbc_host_state_t;
endpackage

/* File: pbc_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Purpose: Joins the clock control block and its host
// Assumes: Single clock domain
// Notes: Byte-wide register port plus system signals
interface pbc_if;
   logic cs;
   logic wr;
   logic rd;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic osc_enable_in;
   logic break_state;
   logic break_clear_enable;
   logic clockgen_irq_out;
   logic base_source_select;
   modport dev (input cs, wr, rd, addr, wdata, osc_enable_in, break_state, break_clear_enable,
      output rdata, clockgen_irq_out, base_source_select);
   modport host (output cs, wr, rd, addr, wdata, osc_enable_in, break_state, break_clear_enable,
      input rdata, clockgen_irq_out, base_source_select);
endinterface
`default_nettype wire

/* File: pbc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Purpose: Two-stage synchroniser for detector levels
// Assumes: Inputs are levels
// Notes: First stage feeds only the second
module pbc_sync #(parameter int W = 2) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         dout <= '0;
      end else if (ce) begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: pbc_dev.sv */
`timescale 1ns/10ps
`default_nettype none
// Purpose: Clock generator digital control: bandwidth, lock, range and multiplier
// Assumes: Analog loop, oscillator and glitch-free switch outside
// Notes: Register reads and writes are single-cycle strobes
module pbc_dev (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   pbc_if.dev bus,
   input wire logic lock_det_in,
   input wire logic track_det_in,
   input wire logic xtal_active_in,
   input wire logic xloss_window_done_in,
   output logic vco_enable,
   output logic acq_force_track,
   output logic auto_mode,
   output logic [3:0] feedback_divide_ratio,
   output logic [3:0] vco_range_field,
   output logic hold_outputs_low
);
   logic irq_en, flag, enable, sel, auto_bit, acq_man, xloss, irq_q, sel_q;
   logic [7:0] rdata_q;
   logic [3:0] mul, vrs;
   logic [1:0] det;
   logic lock_s, track_s, lock_prev;
   logic wr_ctrl, wr_bw, wr_prog, rd_ctrl, clr_ok, lock_edge;

   pbc_sync #(.W(2)) u_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ce(ce),
      .din({lock_det_in, track_det_in}),
      .dout(det)
   );
   assign lock_s = det[1];
   assign track_s = det[0];

   function automatic logic hit(input logic [1:0] a, input logic [1:0] off);
      hit = bus.cs && (a == off);
   endfunction

   assign wr_ctrl = bus.wr && hit(bus.addr, pbc_pkg::pbc_off_ctrl);
   assign wr_bw = bus.wr && hit(bus.addr, pbc_pkg::pbc_off_bw);
   assign wr_prog = bus.wr && hit(bus.addr, pbc_pkg::pbc_off_prog);
   assign rd_ctrl = bus.rd && hit(bus.addr, pbc_pkg::pbc_off_ctrl);
   assign clr_ok = !bus.break_state || bus.break_clear_enable;
   assign lock_edge = auto_bit && (lock_s != lock_prev);

   ////////////////////////////////////////////////////////////////
   // Bandwidth control
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         auto_bit <= 1'b0;
         acq_man <= 1'b0;
         lock_prev <= 1'b0;
      end else if (ce) begin
         lock_prev <= lock_s;
         if (wr_bw) begin
            auto_bit <= bus.wdata[pbc_pkg::pbc_bit_auto];
            if (!auto_bit) begin
               acq_man <= bus.wdata[pbc_pkg::pbc_bit_acq];
            end
         end
      end
   end

   // Crystal loss latch, valid only with VCO selected
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         xloss <= 1'b0;
      end else if (ce) begin
         if (!sel) begin
            xloss <= 1'b0;
         end else if (wr_bw && bus.wdata[pbc_pkg::pbc_bit_xloss]) begin
            xloss <= 1'b1;
         end else if (xloss && xloss_window_done_in && xtal_active_in) begin
            xloss <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Control register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_en <= 1'b0;
         enable <= pbc_pkg::pbc_enable_reset;
         sel <= 1'b0;
      end else if (ce) begin
         if (!bus.osc_enable_in && sel) begin
            sel <= 1'b0;
         end else if (vrs == 4'h0) begin
            enable <= 1'b0;
            sel <= 1'b0;
         end else if (wr_ctrl) begin
            irq_en <= auto_bit && bus.wdata[pbc_pkg::pbc_bit_irq_en];
            // Select may not set while enable is clear; enable held while selected
            enable <= bus.wdata[pbc_pkg::pbc_bit_enable] || sel;
            sel <= bus.wdata[pbc_pkg::pbc_bit_select] && enable;
         end
         if (!auto_bit) begin
            irq_en <= 1'b0;
         end
      end
   end

   // Lock-change flag: set wins over clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         flag <= 1'b0;
      end else if (ce) begin
         if (!auto_bit) begin
            flag <= 1'b0;
         end else if (lock_edge) begin
            flag <= 1'b1;
         end else if (rd_ctrl && clr_ok) begin
            flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Programming register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mul <= pbc_pkg::pbc_mul_reset;
         vrs <= pbc_pkg::pbc_vrs_reset;
      end else if (ce) begin
         if (wr_prog && !enable) begin
            mul <= bus.wdata[pbc_pkg::pbc_mul_lsb +: 4];
            vrs <= bus.wdata[pbc_pkg::pbc_vrs_lsb +: 4];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs and read data; wait mode has no input, so nothing changes
   function automatic logic [7:0] ctrl_image(input logic ie, input logic fl, input logic am,
      input logic en, input logic bs);
      ctrl_image = {ie, fl && am, en, bs, pbc_pkg::pbc_ctrl_low_ones};
   endfunction

   function automatic logic [7:0] bw_image(input logic am, input logic lk, input logic tr,
      input logic ma, input logic xl, input logic bs);
      bw_image = {am, lk && am, am ? tr : ma, xl && bs, 4'h0};
   endfunction

   // Pin gate for stop mode
   function automatic logic run_gate(input logic v);
      run_gate = bus.osc_enable_in && v;
   endfunction

   // Read data follows the address every cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (ce) begin
         unique case (bus.addr)
            pbc_pkg::pbc_off_ctrl: rdata_q <= ctrl_image(irq_en, flag, auto_bit, enable, sel);
            pbc_pkg::pbc_off_bw: rdata_q <= bw_image(auto_bit, lock_s, track_s, acq_man, xloss, sel);
            pbc_pkg::pbc_off_prog: rdata_q <= {mul, vrs};
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // Pins toward system integration
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
         sel_q <= 1'b0;
         hold_outputs_low <= 1'b0;
      end else if (ce) begin
         irq_q <= run_gate(auto_bit && irq_en && flag);
         sel_q <= run_gate(sel);
         hold_outputs_low <= !bus.osc_enable_in;
      end
   end

   // Loop control outputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         vco_enable <= 1'b0;
         acq_force_track <= 1'b0;
         auto_mode <= 1'b0;
      end else if (ce) begin
         vco_enable <= enable;
         acq_force_track <= acq_man;
         auto_mode <= auto_bit;
      end
   end

   // Divider and range outputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         feedback_divide_ratio <= pbc_pkg::pbc_mul_reset;
         vco_range_field <= pbc_pkg::pbc_vrs_reset;
      end else if (ce) begin
         feedback_divide_ratio <= (mul == 4'h0) ? pbc_pkg::pbc_mul_min : mul;
         vco_range_field <= vrs;
      end
   end
   assign bus.rdata = rdata_q;
   assign bus.clockgen_irq_out = irq_q;
   assign bus.base_source_select = sel_q;
endmodule
`default_nettype wire

/* File: pbc_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Purpose: Host end: register access and crystal loss check sequence
// Assumes: User issues one command at a time
// Notes: Writes to bandwidth register keep test bits zero
module pbc_host (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   pbc_if.host bus,
   input wire logic req,
   input wire logic req_wr,
   input wire logic req_xcheck,
   input wire logic [1:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic [3:0] req_mul,
   input wire logic osc_enable,
   input wire logic brk,
   input wire logic brk_clear_en,
   output logic busy,
   output logic done,
   output logic [7:0] rdata
);
   pbc_pkg::pbc_host_state_t st;
   logic [5:0] cnt;
   logic [7:0] wd;
   logic cs_q, wr_q, rd_q;
   logic [1:0] addr_q;
   assign bus.cs = cs_q;
   assign bus.wr = wr_q;
   assign bus.rd = rd_q;
   assign bus.addr = addr_q;
   assign bus.wdata = wd;
   assign bus.osc_enable_in = osc_enable;
   assign bus.break_state = brk;
   assign bus.break_clear_enable = brk_clear_en;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= pbc_pkg::pbc_h_idle;
         cnt <= 6'h00;
         wd <= 8'h00;
         cs_q <= 1'b0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 2'h0;
         busy <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
      end else if (ce) begin
         cs_q <= 1'b0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         done <= 1'b0;
         unique case (st)
            pbc_pkg::pbc_h_idle: begin
               if (req && req_xcheck) begin
                  cs_q <= 1'b1;
                  wr_q <= 1'b1;
                  addr_q <= pbc_pkg::pbc_off_bw;
                  wd <= {req_wdata[7:5], 1'b1, 4'h0};
                  cnt <= 6'((req_mul == 4'h0 ? 6'h01 : {2'h0, req_mul}) * pbc_pkg::pbc_xloss_factor_w);
                  busy <= 1'b1;
                  st <= pbc_pkg::pbc_h_wait;
               end else if (req) begin
                  cs_q <= 1'b1;
                  wr_q <= req_wr;
                  rd_q <= !req_wr;
                  addr_q <= req_addr;
                  wd <= (req_addr == pbc_pkg::pbc_off_bw) ? {req_wdata[7:4], 4'h0} : req_wdata;
                  busy <= 1'b1;
                  st <= pbc_pkg::pbc_h_take;
               end
            end
            pbc_pkg::pbc_h_wait: begin
               if (cnt == 6'h00) begin
                  cs_q <= 1'b1;
                  rd_q <= 1'b1;
                  st <= pbc_pkg::pbc_h_take;
               end else begin
                  cnt <= cnt - 6'h01;
               end
            end
            // Read data settles one cycle after the strobe
            pbc_pkg::pbc_h_take: begin
               st <= pbc_pkg::pbc_h_done;
            end
            pbc_pkg::pbc_h_done: begin
               rdata <= bus.rdata;
               done <= 1'b1;
               busy <= 1'b0;
               st <= pbc_pkg::pbc_h_idle;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: pbc_checker.sv */
// Purpose: Interface checks for the loop clock control link
// Assumes: One clock, ce held high
// Notes: Sees interface signals only
`timescale 1ns/10ps
`default_nettype none
module pbc_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cs,
   input wire logic wr,
   input wire logic rd,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic osc_enable_in,
   input wire logic break_state,
   input wire logic break_clear_enable,
   input wire logic clockgen_irq_out,
   input wire logic base_source_select
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   sequence s_brk_rd;
      cs && rd && !wr && addr == pbc_pkg::pbc_off_ctrl && break_state && !break_clear_enable;
   endsequence
   property p_brk_keep;
      s_brk_rd ##0 (osc_enable_in && clockgen_irq_out) |=> clockgen_irq_out;
   endproperty
   property p_stop_sel;
      !osc_enable_in |=> !base_source_select;
   endproperty
   property p_stop_irq;
      !osc_enable_in |=> !clockgen_irq_out;
   endproperty
   property p_sel_cause;
      $rose(base_source_select) |-> $past(cs && wr && addr == pbc_pkg::pbc_off_ctrl
         && wdata[pbc_pkg::pbc_bit_select], 2);
   endproperty
   property p_lock_manual;
      $past(addr == pbc_pkg::pbc_off_bw) && !rdata[7] |-> !rdata[6];
   endproperty
   property p_xld_sel;
      $past(addr == pbc_pkg::pbc_off_bw) && !$past(base_source_select) |-> !rdata[4];
   endproperty
   property p_test_bits;
      cs && wr && addr == pbc_pkg::pbc_off_bw |-> wdata[3:0] == 4'h0;
   endproperty
   property p_irq_fall;
      $fell(clockgen_irq_out) |-> $past(cs) || $past(cs, 2) || $past(!osc_enable_in);
   endproperty
   a_brk_keep: assert property (p_brk_keep) else $error("flag lost in break");
   a_stop_sel: assert property (p_stop_sel) else $error("select kept in stop");
   a_stop_irq: assert property (p_stop_irq) else $error("irq high in stop");
   a_sel_cause: assert property (p_sel_cause) else $error("select rose unasked");
   a_lock_manual: assert property (p_lock_manual) else $error("lock in manual");
   a_xld_sel: assert property (p_xld_sel) else $error("xloss without select");
   a_test_bits: assert property (p_test_bits) else $error("test bits set");
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Both ends joined, driven through the host request port
// Assumes: ce held high
// Notes: Detector levels driven by the bench
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [1:0] ctl = pbc_pkg::pbc_off_ctrl;
   localparam logic [1:0] bwr = pbc_pkg::pbc_off_bw;
   localparam logic [1:0] prg = pbc_pkg::pbc_off_prog;
   logic sys_clk, nrst, ce, lock_det_in, track_det_in, xtal_active_in, xloss_window_done_in;
   logic req, req_wr, req_xcheck, osc_enable, brk, brk_clear_en, busy, done;
   logic vco_enable, acq_force_track, auto_mode, hold_outputs_low;
   logic [1:0] req_addr;
   logic [3:0] req_mul, feedback_divide_ratio, vco_range_field;
   logic [7:0] req_wdata, rdata, rd_val;
   int errors, num_checks, n, cycles;
   pbc_if bus_if ();
   pbc_dev pbc_dev_inst (.sys_clk, .nrst, .ce, .bus(bus_if), .lock_det_in, .track_det_in,
      .xtal_active_in, .xloss_window_done_in, .vco_enable, .acq_force_track, .auto_mode,
      .feedback_divide_ratio, .vco_range_field, .hold_outputs_low);
   pbc_host pbc_host_inst (.sys_clk, .nrst, .ce, .bus(bus_if), .req, .req_wr, .req_xcheck, .req_addr,
      .req_wdata, .req_mul, .osc_enable, .brk, .brk_clear_en, .busy, .done, .rdata);
   pbc_checker pbc_checker_inst (.sys_clk, .nrst, .cs(bus_if.cs), .wr(bus_if.wr), .rd(bus_if.rd),
      .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .osc_enable_in(bus_if.osc_enable_in),
      .break_state(bus_if.break_state), .break_clear_enable(bus_if.break_clear_enable),
      .clockgen_irq_out(bus_if.clockgen_irq_out), .base_source_select(bus_if.base_source_select));
   ////////////////////////////////////////
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d, input logic x);
      tick(1);
      {req, req_wr, req_xcheck, req_addr, req_wdata} = {1'b1, w, x, a, d};
      tick(1);
      req = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      rd_val = rdata;
   endtask
   task automatic wrt(input logic [1:0] a, input logic [7:0] d);
      acc(1'b1, a, d, 1'b0);
   endtask
   task automatic rdx(input logic [1:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00, 1'b0);
      chk(rd_val, exp);
   endtask
   task automatic xc(input logic [7:0] exp);
      acc(1'b0, bwr, 8'h00, 1'b1);
      chk(rd_val & 8'h10, exp);
      chk(8'(n >= pbc_pkg::pbc_xloss_factor * req_mul), 8'h01);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      {nrst, ce, lock_det_in, track_det_in, xtal_active_in, xloss_window_done_in} = 6'h13;
      {req, req_wr, req_xcheck, req_addr, req_wdata} = 13'h0000;
      {req_mul, osc_enable, brk, brk_clear_en} = 7'h34;
      tick(4);
      nrst = 1'b1;
      rdx(ctl, 8'h2F);
      rdx(bwr, 8'h00);
      rdx(prg, 8'h66);
      chk({feedback_divide_ratio, vco_range_field}, 8'h66);
      chk({6'h00, auto_mode, acq_force_track}, 8'h00);
      wrt(prg, 8'h35);
      rdx(prg, 8'h66);
      wrt(ctl, 8'h00);
      wrt(prg, 8'h00);
      chk({feedback_divide_ratio, vco_range_field}, 8'h10);
      wrt(ctl, 8'h20);
      wrt(ctl, 8'h30);
      chk({6'h00, vco_enable, bus_if.base_source_select}, 8'h00);
      wrt(ctl, 8'h00);
      wrt(prg, 8'hF3);
      chk({feedback_divide_ratio, vco_range_field}, 8'hF3);
      wrt(ctl, 8'h10);
      chk(8'(bus_if.base_source_select), 8'h00);
      chk(8'(acq_force_track), 8'h00);
      wrt(ctl, 8'h20);
      wrt(ctl, 8'h30);
      chk({6'h00, vco_enable, bus_if.base_source_select}, 8'h03);
      req_mul = 4'hF;
      xtal_active_in = 1'b0;
      xc(8'h10);
      xtal_active_in = 1'b1;
      xc(8'h00);
      xtal_active_in = 1'b0;
      osc_enable = 1'b0;
      tick(3);
      chk({5'h00, hold_outputs_low, bus_if.clockgen_irq_out, bus_if.base_source_select}, 8'h04);
      osc_enable = 1'b1;
      tick(3);
      chk(8'(bus_if.base_source_select), 8'h00);
      xc(8'h00);
      wrt(bwr, 8'h00);
      wrt(bwr, 8'h20);
      chk(8'(acq_force_track), 8'h01);
      wrt(bwr, 8'hA0);
      wrt(ctl, 8'hA0);
      {lock_det_in, track_det_in} = 2'h3;
      tick(8);
      chk(8'(bus_if.clockgen_irq_out), 8'h01);
      rdx(bwr, 8'hE0);
      track_det_in = 1'b0;
      tick(6);
      rdx(bwr, 8'hC0);
      brk = 1'b1;
      rdx(ctl, 8'hEF);
      rdx(ctl, 8'hEF);
      brk = 1'b0;
      rdx(ctl, 8'hEF);
      rdx(ctl, 8'hAF);
      lock_det_in = 1'b0;
      tick(8);
      {brk, brk_clear_en} = 2'h3;
      rdx(ctl, 8'hEF);
      brk = 1'b0;
      rdx(ctl, 8'hAF);
      lock_det_in = 1'b1;
      tick(8);
      wrt(bwr, 8'h00);
      chk(8'(bus_if.clockgen_irq_out), 8'h00);
      rdx(ctl, 8'h2F);
      rdx(bwr, 8'h20);
      chk(8'(acq_force_track), 8'h01);
      tally_and_finish();
   end
endmodule
`default_nettype wire
